// ===== dv/acq_seq_assertions.sv
module acq_seq_assertions
	import acq_pkg::*;
#(
	parameter int CW = 4
)
(
	input wire logic          pclk,
	input wire logic          presetn,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [7:0]    paddr,
	input wire logic [31:0]   prdata,
	input wire logic          pready,
	input wire logic          pslverr,
	input wire logic          in_convert,
	input wire logic [CW-1:0] in_chan,
	input wire logic          in_read,
	input wire logic          out_update,
	input wire logic [CW-1:0] out_chan
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [CW-1:0] last_in_reg;
	logic [CW-1:0] last_out_reg;

	// channel of the previous strobe, to see the list advance by one
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			last_in_reg <= '0;
		else if (in_convert)
			last_in_reg <= in_chan;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			last_out_reg <= '0;
		else if (out_update)
			last_out_reg <= out_chan;

	////////////////////////////////////////////////////////////////////////
	property p_read_at_strobe;
		in_read |-> in_convert;
	endproperty
	a_read_at_strobe: assert property (p_read_at_strobe)
		else $error("read without a conversion strobe");

	property p_in_order;
		in_convert && in_chan != '0 |-> in_chan == last_in_reg + 1'b1;
	endproperty
	a_in_order: assert property (p_in_order)
		else $error("input channel skipped");

	property p_out_order;
		out_update && out_chan != '0 |-> out_chan == last_out_reg + 1'b1;
	endproperty
	a_out_order: assert property (p_out_order)
		else $error("output channel skipped");

	property p_in_hold;
		!in_convert |-> $stable(in_chan);
	endproperty
	a_in_hold: assert property (p_in_hold)
		else $error("input channel moved between strobes");

	property p_quiet_after_reset;
		!$past(presetn) |-> (!in_convert && !out_update && !in_read)[*2];
	endproperty
	a_quiet_after_reset: assert property (p_quiet_after_reset)
		else $error("strobe right after reset");

	property p_unmapped;
		psel && penable && (paddr > 8'h2C || paddr[1:0] != 2'h0)
			|-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");

	property p_mapped;
		psel && penable && paddr <= 8'h2C && paddr[1:0] == 2'h0 |-> !pslverr;
	endproperty
	a_mapped: assert property (p_mapped)
		else $error("mapped access refused");

	property p_ready;
		psel |-> pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("wait state inserted");

	property p_ctrl_zero;
		psel && penable && !pwrite && paddr == 8'h00 |-> prdata == 32'h0;
	endproperty
	a_ctrl_zero: assert property (p_ctrl_zero)
		else $error("control register read not zero");
endmodule

// ===== dv/ext_source.sv
module ext_source
(
	output logic in_trig_pin,
	output logic in_clk_pin,
	output logic out_trig_pin,
	output logic out_clk_pin
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		in_trig_pin = 1'b0;
		in_clk_pin = 1'b0;
		out_trig_pin = 1'b0;
		out_clk_pin = 1'b0;
	end

	// offset of 1 ns keeps pin edges off the sampling edge
	task automatic trig(input bit outp, input int ns);
		#1;
		if (outp) out_trig_pin = 1'b1; else in_trig_pin = 1'b1;
		#(ns > 60 ? ns : 64);
		if (outp) out_trig_pin = 1'b0; else in_trig_pin = 1'b0;
	endtask

	// clock rests low outside a burst; 1 ns keeps edges off pclk edges
	task automatic clocks(input bit outp, input int n);
		#1;
		repeat (n)
		begin
			#24;
			if (outp) out_clk_pin = 1'b1; else in_clk_pin = 1'b1;
			#24;
			if (outp) out_clk_pin = 1'b0; else in_clk_pin = 1'b0;
			// rest so each edge leaves the interval plus sync time
			#200;
		end
	endtask

	task automatic trig_clock(input bit outp);
		fork
			trig(outp, 200);
			begin
				#60;
				clocks(outp, 1);
			end
		join
	endtask
endmodule

// ===== dv/tb_top.sv
`include "acq_params.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int CW = 4;
	logic          pclk;
	logic          presetn;
	logic          psel;
	logic          penable;
	logic          pwrite;
	logic [7:0]    paddr;
	logic [31:0]   pwdata;
	logic [31:0]   prdata;
	logic [31:0]   rdata;
	logic          pready;
	logic          pslverr;
	logic          err;
	logic          in_trig_pin;
	logic          in_clk_pin;
	logic          out_trig_pin;
	logic          out_clk_pin;
	logic          in_convert;
	logic          in_read;
	logic          out_update;
	logic [CW-1:0] in_chan;
	logic [CW-1:0] in_read_chan;
	logic [CW-1:0] out_chan;
	logic [CW-1:0] rd_chan;
	int            fails;
	int            total_checks;
	int            conv;
	int            upd;
	int            rds;
	int            base;
	int            n;

	acq_trigger_clock_sequencer #(.CW(CW)) acq_trigger_clock_sequencer_i
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .in_trig_pin, .in_clk_pin, .out_trig_pin,
		.out_clk_pin, .in_convert, .in_chan, .in_read, .in_read_chan,
		.out_update, .out_chan
	);

	ext_source ext_source_i
	(
		.in_trig_pin, .in_clk_pin, .out_trig_pin, .out_clk_pin
	);

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	always @(negedge pclk)
	begin
		conv += int'(in_convert === 1'b1);
		upd += int'(out_update === 1'b1);
		rds += int'(in_read === 1'b1);
		if (in_read === 1'b1)
			rd_chan = in_read_chan;
	end

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic check(input string name, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (5000) @(posedge pclk);
		fails++;
		$display("Error watchdog expected end seen hang");
		tally_and_finish;
	end

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		xfer(0, `OFS_IN_CFG, 0); check("in_cfg", rdata, `CFG_RESET);
		xfer(0, `OFS_OUT_CFG, 0); check("out_cfg", rdata, `CFG_RESET);
		xfer(0, `OFS_OUT_TIME, 0); check("out_time", rdata, 32'h19);
		xfer(0, `OFS_CTRL, 0); check("ctrl", rdata, 32'h0);
		xfer(0, 8'h40, 0); check("unmapped", {err, rdata[30:0]}, 32'h8000_0000);
		$display("test reset done");
		xfer(1, `OFS_IN_TIME, 32'h2);
		xfer(1, `OFS_IN_COUNT, 32'h4);
		xfer(1, `OFS_IN_CFG, 32'h104);
		base = conv;
		n = rds;
		xfer(1, `OFS_CTRL, 32'h1);
		repeat (30) @(posedge pclk);
		check("convs", 32'(conv - base), 32'h4);
		check("reads", 32'(rds - n), 32'h3);
		xfer(0, `OFS_IN_DONE, 0); check("in_done", rdata, 32'h4);
		$display("test internal done");
		xfer(1, `OFS_IN_COUNT, 32'h2);
		xfer(1, `OFS_IN_CFG, 32'h105);
		base = conv;
		xfer(1, `OFS_CTRL, 32'h1);
		repeat (20) @(posedge pclk);
		check("armed", 32'(conv - base), 32'h0);
		fork ext_source_i.trig(1'b0, 100); join_none
		n = 0;
		while (in_convert !== 1'b1 && n < 20)
		begin
			@(negedge pclk);
			n++;
		end
		check("align", 32'(n >= 3 && n <= 7), 32'h1);
		repeat (20) @(posedge pclk);
		check("single_start_mode", 32'(conv - base), 32'h2);
		xfer(0, `OFS_IN_STAMP, 0);
		check("stamp", rdata, 32'h2);
		$display("test single_start_mode done");
		xfer(1, `OFS_IN_COUNT, 32'h0);
		xfer(1, `OFS_IN_CFG, 32'h102);
		base = conv;
		xfer(1, `OFS_CTRL, 32'h1);
		fork ext_source_i.trig(1'b0, 80); join_none
		repeat (40) @(posedge pclk);
		n = conv;
		check("gate_run", 32'(n > base), 32'h1);
		repeat (30) @(posedge pclk);
		check("gate_halt", 32'(conv), 32'(n));
		fork ext_source_i.trig(1'b0, 80); join_none
		repeat (40) @(posedge pclk);
		check("gate_resume", 32'(conv > n), 32'h1);
		xfer(1, `OFS_CTRL, 32'h2);
		$display("test gated done");
		xfer(1, `OFS_IN_CFG, 32'h118);
		base = conv;
		n = rds;
		xfer(1, `OFS_CTRL, 32'h1);
		ext_source_i.clocks(1'b0, 5);
		repeat (10) @(posedge pclk);
		check("ext_convs", 32'(conv - base), 32'h4);
		check("ctr_reads", 32'(rds - n), 32'h2);
		check("rd_chan", 32'(rd_chan), 32'h1);
		xfer(1, `OFS_CTRL, 32'h2);
		$display("test ext input done");
		xfer(1, `OFS_OUT_TIME, 32'h2);
		xfer(1, `OFS_OUT_CFG, 32'h20C);
		base = upd;
		xfer(1, `OFS_CTRL, 32'h4);
		ext_source_i.clocks(1'b1, 1);
		repeat (10) @(posedge pclk);
		check("list_upd", 32'(upd - base), 32'h3);
		xfer(1, `OFS_CTRL, 32'h8);
		xfer(1, `OFS_OUT_CFG, 32'h208);
		base = upd;
		xfer(1, `OFS_CTRL, 32'h4);
		ext_source_i.clocks(1'b1, 2);
		repeat (10) @(posedge pclk);
		check("single_upd", 32'(upd - base), 32'h2);
		xfer(1, `OFS_CTRL, 32'h8);
		xfer(1, `OFS_OUT_CFG, 32'h20D);
		base = upd;
		xfer(1, `OFS_CTRL, 32'h4);
		ext_source_i.clocks(1'b1, 2);
		repeat (10) @(posedge pclk);
		check("no_trig", 32'(upd - base), 32'h0);
		ext_source_i.trig_clock(1'b1);
		repeat (10) @(posedge pclk);
		check("trig_clk", 32'(upd - base), 32'h3);
		xfer(1, `OFS_CTRL, 32'h8);
		xfer(1, `OFS_OUT_CFG, 32'h202);
		base = upd;
		xfer(1, `OFS_CTRL, 32'h4);
		fork ext_source_i.trig(1'b1, 80); join_none
		repeat (40) @(posedge pclk);
		n = upd;
		check("out_gate_run", 32'(n > base), 32'h1);
		repeat (30) @(posedge pclk);
		check("out_gate_halt", 32'(upd), 32'(n));
		xfer(1, `OFS_CTRL, 32'h8);
		$display("test output done");
		tally_and_finish;
	end
endmodule

bind acq_trigger_clock_sequencer acq_seq_assertions #(.CW(CW))
	acq_seq_assertions_i
(
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
	.pslverr, .in_convert, .in_chan, .in_read, .out_update, .out_chan
);

// ===== rtl/acq_params.svh
`ifndef ACQ_PARAMS_SVH
`define ACQ_PARAMS_SVH

`define OFS_CTRL      8'h00
`define OFS_IN_CFG    8'h04
`define OFS_IN_TIME   8'h08
`define OFS_IN_COUNT  8'h0C
`define OFS_OUT_CFG   8'h10
`define OFS_OUT_TIME  8'h14
`define OFS_OUT_COUNT 8'h18
`define OFS_STATUS    8'h1C
`define OFS_IN_DONE   8'h20
`define OFS_IN_STAMP  8'h24
`define OFS_OUT_DONE  8'h28
`define OFS_OUT_STAMP 8'h2C

`define CTRL_IN_START  0
`define CTRL_IN_STOP   1
`define CTRL_OUT_START 2
`define CTRL_OUT_STOP  3

`define CFG_MODE_LSB   0
`define CFG_MODE_MSB   1
`define CFG_LIST       2
`define CFG_EXT        3
`define CFG_FIRST_CTR  4
`define CFG_LAST_LSB   8

`define CFG_RESET      32'h0000_0004
`define TIME_RESET     16'h0019
`define COUNT_RESET    32'h0000_0000
`endif

// ===== rtl/acq_pkg.sv
package acq_pkg;
	typedef enum logic [1:0]
	{
		TRIG_OFF     = 2'h0,
		TRIG_SINGLE_START_MODE = 2'h1,
		TRIG_GATED   = 2'h2
	} trig_mode_t;

	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_ARMED,
		ST_RUN
	} seq_state_t;
endpackage

// ===== rtl/acq_trigger_clock_sequencer.sv
`include "acq_params.svh"

////////////////////////////////////////////////////////////////////////////
module seq_engine
	import acq_pkg::*;
#(
	parameter bit IS_INPUT = 1'b1,
	parameter int CW       = 4
)
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          start,
	input  wire logic          stop,
	input  wire logic [1:0]    mode,
	input  wire logic          list_clock_select,
	input  wire logic          ext_en,
	input  wire logic          first_counter,
	input  wire logic [CW-1:0] last_chan,
	input  wire logic [15:0]   interval,
	input  wire logic [31:0]   count,
	input  wire logic          trig_rise,
	input  wire logic          trig_level,
	input  wire logic          clk_rise,
	output logic               active,
	output logic               strobe,
	output logic [CW-1:0]      chan,
	output logic               read_strobe,
	output logic [CW-1:0]      read_chan,
	output logic [31:0]        done,
	output logic [31:0]        stamp
);
	seq_state_t    state_reg;
	logic          fired_reg;
	logic          skip_reg;
	logic [CW-1:0] chan_reg;
	logic [15:0]   tmr_reg;
	logic [31:0]   done_reg;
	logic [31:0]   since_reg;
	logic [1:0]    pv_reg;
	logic [CW-1:0] pc0_reg;
	logic [CW-1:0] pc1_reg;
	logic          gate;
	logic          clk_ok;
	logic          boundary;
	logic          fire;
	logic          halt;
	logic          last;
	logic [CW-1:0] chan_next;
	logic [15:0]   reload;

	if (CW < 1 || CW > 8)
	begin : g_chk
		$error("seq_engine: CW out of range");
	end

	always_comb
	begin
		unique case (mode)
			TRIG_SINGLE_START_MODE: gate = fired_reg | trig_rise;
			TRIG_GATED:   gate = trig_level;
			default:      gate = 1'b1;
		endcase
	end

	// input path ignores the first external edge, output path takes it
	assign clk_ok    = ext_en ? (clk_rise & ~skip_reg) : 1'b1;
	assign boundary  = list_clock_select ? (chan_reg == '0) : 1'b1;
	assign chan_next = (chan_reg == last_chan) ? '0 : chan_reg + 1'b1;
	assign reload    = (interval == 16'h0000) ? 16'h0000 : interval - 1'b1;
	assign last      = (count != 32'h0000_0000) && (done_reg + 1'b1 == count);

	always_comb
	begin
		fire = 1'b0;
		halt = 1'b0;
		unique case (state_reg)
			ST_ARMED: fire = gate & clk_ok;
			ST_RUN:
			begin
				if (tmr_reg == 16'h0000)
				begin
					// mid-list channels ignore the gate
					fire = ~boundary | (~ext_en & gate);
					halt = ~fire;
				end
			end
			ST_IDLE: fire = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= ST_IDLE;
		else if (stop)
			state_reg <= ST_IDLE;
		else if (state_reg == ST_IDLE)
		begin
			if (start)
				state_reg <= ST_ARMED;
		end
		else if (fire)
		begin
			if (last)
				state_reg <= ST_IDLE;
			else if (ext_en && (chan_next == '0 || !list_clock_select))
				state_reg <= ST_ARMED;
			else
				state_reg <= ST_RUN;
		end
		else if (halt)
			state_reg <= ST_ARMED;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			chan_reg <= '0;
			tmr_reg  <= 16'h0000;
			done_reg <= 32'h0000_0000;
		end
		else if (start && state_reg == ST_IDLE)
		begin
			chan_reg <= '0;
			tmr_reg  <= 16'h0000;
			done_reg <= 32'h0000_0000;
		end
		else if (fire)
		begin
			chan_reg <= chan_next;
			tmr_reg  <= reload;
			done_reg <= done_reg + 1'b1;
		end
		else if (state_reg == ST_RUN && tmr_reg != 16'h0000)
			tmr_reg <= tmr_reg - 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fired_reg <= 1'b0;
			skip_reg  <= 1'b0;
		end
		else if (start && state_reg == ST_IDLE)
		begin
			fired_reg <= 1'b0;
			skip_reg  <= IS_INPUT;
		end
		else
		begin
			if (trig_rise && state_reg != ST_IDLE)
				fired_reg <= 1'b1;
			if (clk_rise && state_reg != ST_IDLE)
				skip_reg <= 1'b0;
		end
	end

	// time base restarts at every trigger event so stamps are per event
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			since_reg <= 32'h0000_0000;
		else if ((start && state_reg == ST_IDLE) || trig_rise)
			since_reg <= 32'h0000_0000;
		else
			since_reg <= since_reg + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strobe <= 1'b0;
			chan   <= '0;
			stamp  <= 32'h0000_0000;
		end
		else
		begin
			strobe <= fire;
			if (fire)
			begin
				chan  <= chan_reg;
				// the edge-aligned strobe itself counts as time zero
				stamp <= trig_rise ? 32'h0000_0000
					: since_reg + 1'b1;
			end
		end
	end

	// each conversion is read at the next strobe, or two later with first_counter, if that strobe comes; the strobes before that issue no read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pv_reg      <= 2'h0;
			pc0_reg     <= '0;
			pc1_reg     <= '0;
			read_strobe <= 1'b0;
			read_chan   <= '0;
		end
		else if (start && state_reg == ST_IDLE)
		begin
			pv_reg      <= 2'h0;
			read_strobe <= 1'b0;
		end
		else
		begin
			read_strobe <= IS_INPUT & fire &
				(first_counter ? pv_reg[1] : pv_reg[0]);
			if (fire)
			begin
				pv_reg    <= {pv_reg[0], 1'b1};
				pc0_reg   <= chan_reg;
				pc1_reg   <= pc0_reg;
				read_chan <= first_counter ? pc1_reg : pc0_reg;
			end
		end
	end

	assign active = (state_reg != ST_IDLE);
	assign done   = done_reg;
endmodule

////////////////////////////////////////////////////////////////////////////
module acq_trigger_clock_sequencer
	import acq_pkg::*;
#(
	parameter int CW = 4
)
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          in_trig_pin,
	input  wire logic          in_clk_pin,
	input  wire logic          out_trig_pin,
	input  wire logic          out_clk_pin,
	output logic               in_convert,
	output logic [CW-1:0]      in_chan,
	output logic               in_read,
	output logic [CW-1:0]      in_read_chan,
	output logic               out_update,
	output logic [CW-1:0]      out_chan
);
	logic [3:0]    sync1_reg;
	logic [3:0]    sync2_reg;
	logic [3:0]    sync3_reg;
	logic [3:0]    pin_rise;
	logic [31:0]   in_cfg_reg;
	logic [31:0]   out_cfg_reg;
	logic [15:0]   in_time_reg;
	logic [15:0]   out_time_reg;
	logic [31:0]   in_count_reg;
	logic [31:0]   out_count_reg;
	logic [3:0]    ctrl_pulse;
	logic          in_active;
	logic          out_active;
	logic [31:0]   in_done;
	logic [31:0]   in_stamp;
	logic [31:0]   out_done;
	logic [31:0]   out_stamp;
	logic          wr_en;
	logic          setup;
	logic [31:0]   rd_val;
	logic          rd_bad;

	////////////////////////////////////////////////////////////////////////
	// three stages: two to settle, the third only for edge finding
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			sync3_reg <= 4'h0;
		end
		else
		begin
			sync1_reg <= {out_clk_pin, out_trig_pin, in_clk_pin, in_trig_pin};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	assign pin_rise = sync2_reg & ~sync3_reg;

	////////////////////////////////////////////////////////////////////////
	assign pready = 1'b1;
	assign setup  = psel & ~penable;
	assign wr_en  = psel & penable & pwrite & ~pslverr;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			in_cfg_reg    <= `CFG_RESET;
			out_cfg_reg   <= `CFG_RESET;
			in_time_reg   <= `TIME_RESET;
			out_time_reg  <= `TIME_RESET;
			in_count_reg  <= `COUNT_RESET;
			out_count_reg <= `COUNT_RESET;
		end
		else if (wr_en)
		begin
			unique case (paddr)
				`OFS_IN_CFG:    in_cfg_reg    <= pwdata;
				`OFS_OUT_CFG:   out_cfg_reg   <= pwdata;
				`OFS_IN_TIME:   in_time_reg   <= pwdata[15:0];
				`OFS_OUT_TIME:  out_time_reg  <= pwdata[15:0];
				`OFS_IN_COUNT:  in_count_reg  <= pwdata;
				`OFS_OUT_COUNT: out_count_reg <= pwdata;
				default:        ;
			endcase
		end
	end

	// start and stop are write-one pulses, never stored
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_pulse <= 4'h0;
		else if (wr_en && paddr == `OFS_CTRL)
			ctrl_pulse <= pwdata[3:0];
		else
			ctrl_pulse <= 4'h0;
	end

	always_comb
	begin
		rd_bad = 1'b0;
		unique case (paddr)
			`OFS_CTRL:      rd_val = 32'h0000_0000;
			`OFS_IN_CFG:    rd_val = in_cfg_reg;
			`OFS_OUT_CFG:   rd_val = out_cfg_reg;
			`OFS_IN_TIME:   rd_val = {16'h0000, in_time_reg};
			`OFS_OUT_TIME:  rd_val = {16'h0000, out_time_reg};
			`OFS_IN_COUNT:  rd_val = in_count_reg;
			`OFS_OUT_COUNT: rd_val = out_count_reg;
			`OFS_STATUS:    rd_val = {30'h0, out_active, in_active};
			`OFS_IN_DONE:   rd_val = in_done;
			`OFS_IN_STAMP:  rd_val = in_stamp;
			`OFS_OUT_DONE:  rd_val = out_done;
			`OFS_OUT_STAMP: rd_val = out_stamp;
			default:
			begin
				rd_val = 32'h0000_0000;
				rd_bad = 1'b1;
			end
		endcase
	end

	// answer is captured in setup so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_val;
			pslverr <= rd_bad;
		end
	end

	////////////////////////////////////////////////////////////////////////
	seq_engine #(.IS_INPUT(1'b1), .CW(CW)) u_in
	(
		.pclk              (pclk),
		.presetn           (presetn),
		.start             (ctrl_pulse[`CTRL_IN_START]),
		.stop              (ctrl_pulse[`CTRL_IN_STOP]),
		.mode              (in_cfg_reg[`CFG_MODE_MSB:`CFG_MODE_LSB]),
		.list_clock_select (in_cfg_reg[`CFG_LIST]),
		.ext_en            (in_cfg_reg[`CFG_EXT]),
		.first_counter     (in_cfg_reg[`CFG_FIRST_CTR]),
		.last_chan         (in_cfg_reg[`CFG_LAST_LSB +: CW]),
		.interval          (in_time_reg),
		.count             (in_count_reg),
		.trig_rise         (pin_rise[0]),
		.trig_level        (sync2_reg[0]),
		.clk_rise          (pin_rise[1]),
		.active            (in_active),
		.strobe            (in_convert),
		.chan              (in_chan),
		.read_strobe       (in_read),
		.read_chan         (in_read_chan),
		.done              (in_done),
		.stamp             (in_stamp)
	);

	seq_engine #(.IS_INPUT(1'b0), .CW(CW)) u_out
	(
		.pclk              (pclk),
		.presetn           (presetn),
		.start             (ctrl_pulse[`CTRL_OUT_START]),
		.stop              (ctrl_pulse[`CTRL_OUT_STOP]),
		.mode              (out_cfg_reg[`CFG_MODE_MSB:`CFG_MODE_LSB]),
		.list_clock_select (out_cfg_reg[`CFG_LIST]),
		.ext_en            (out_cfg_reg[`CFG_EXT]),
		.first_counter     (1'b0),
		.last_chan         (out_cfg_reg[`CFG_LAST_LSB +: CW]),
		.interval          (out_time_reg),
		.count             (out_count_reg),
		.trig_rise         (pin_rise[2]),
		.trig_level        (sync2_reg[2]),
		.clk_rise          (pin_rise[3]),
		.active            (out_active),
		.strobe            (out_update),
		.chan              (out_chan),
		.read_strobe       (),
		.read_chan         (),
		.done              (out_done),
		.stamp             (out_stamp)
	);
endmodule
